/* design/usb_rx_susp_pkg.sv */
package usb_rx_susp_pkg;
    // register offsets (byte addresses)
    localparam logic [4:0] OFS_POWER   = 5'h00;
    localparam logic [4:0] OFS_RX_CSR  = 5'h04;
    localparam logic [4:0] OFS_DMA_CTL = 5'h08;
    localparam logic [4:0] OFS_DMA_CNT = 5'h0c;
    localparam logic [4:0] OFS_IRQ_ST  = 5'h10;
    localparam logic [4:0] OFS_IRQ_EN  = 5'h14;
    localparam logic [4:0] OFS_IRQ_CLR = 5'h18;
    // power register fields
    localparam int PWR_HOST    = 0;
    localparam int PWR_SUSPEND = 1;
    localparam int PWR_RESUME  = 2;
    localparam int PWR_RESET   = 3;
    localparam int PWR_STATE   = 4;
    // receive control/status fields
    localparam int RX_READY    = 0;
    localparam int RX_SHORT    = 1;
    localparam int RX_REQ_MODE = 3;
    localparam int RX_REQ_EN   = 5;
    // dma channel control fields
    localparam int DMA_EN      = 0;
    localparam int DMA_MODE    = 2;
    // interrupt bits
    localparam int IRQ_N       = 5;
    localparam int IRQ_RX      = 0;
    localparam int IRQ_DMA     = 1;
    localparam int IRQ_BUS_RST = 2;
    localparam int IRQ_RESUMED = 3;
    localparam int IRQ_RST_END = 4;
    // reset values
    localparam logic [15:0]      DMA_CNT_RST = 16'h0000;
    localparam logic [IRQ_N-1:0] IRQ_RST     = 5'h00;
    // timing
    localparam int CLK_MHZ        = 100;
    localparam int RESUME_TIME_US = 20;
    localparam int RESET_TIME_US  = 50;
    localparam int SE0_DET_NS     = 2500;
    localparam int RESUME_CYC     = RESUME_TIME_US * CLK_MHZ;
    localparam int RESET_CYC      = RESET_TIME_US * CLK_MHZ;
    localparam int SE0_DET_CYC    = (SE0_DET_NS * CLK_MHZ + 999) / 1000;
    // bus power states, gray except for resuming to active and suspended to resetting
    typedef enum logic [1:0] {
        BUS_ACTIVE    = 2'b00,
        BUS_SUSPENDED = 2'b01,
        BUS_RESUMING  = 2'b11,
        BUS_RESETTING = 2'b10
    } bus_state_t;
endpackage

/* design/usb_bus_power_seq.sv */
`timescale 1ns/1ns
module usb_bus_power_seq
    import usb_rx_susp_pkg::*;
#(
    parameter int unsigned RESUME_LEN = RESUME_CYC,
    parameter int unsigned RESET_LEN  = RESET_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic host_role,
    input  wire logic suspend_req,
    input  wire logic resume_cmd,
    input  wire logic reset_cmd,
    input  wire logic se0,
    output bus_state_t state,
    output logic       ev_bus_reset,
    output logic       ev_resumed,
    output logic       ev_reset_end
);
    typedef struct packed {
        bus_state_t  st;
        logic [31:0] cnt;
        logic [11:0] se0_cnt;
        logic        ev_bus_reset;
        logic        ev_resumed;
        logic        ev_reset_end;
    } seq_t;

    seq_t s_reg, s_next;
    localparam logic [11:0] SE0_LAST = 12'(SE0_DET_CYC - 1);

    // next-state: both roles suspend on request, host drives resume/reset, peripheral watches for se0
    always_comb begin
        s_next = s_reg;
        s_next.ev_bus_reset = 1'b0;
        s_next.ev_resumed = 1'b0;
        s_next.ev_reset_end = 1'b0;
        s_next.se0_cnt = se0 ? ((s_reg.se0_cnt == SE0_LAST) ? s_reg.se0_cnt : s_reg.se0_cnt + 12'h001) : 12'h000;
        case (s_reg.st)
            BUS_ACTIVE: begin
                if (host_role && reset_cmd) begin
                    s_next.st = BUS_RESETTING;
                    s_next.cnt = 32'h0;
                end else if (suspend_req && !s_reg.ev_bus_reset) begin
                    // one cycle of grace after a bus reset, so the cleared request lands first
                    s_next.st = BUS_SUSPENDED;
                end
            end
            BUS_SUSPENDED: begin
                // reset leaves suspend directly; no resume needed first
                if (host_role && reset_cmd) begin
                    s_next.st = BUS_RESETTING;
                    s_next.cnt = 32'h0;
                end else if (host_role && resume_cmd) begin
                    s_next.st = BUS_RESUMING;
                    s_next.cnt = 32'h0;
                end else if (!host_role && !suspend_req) begin
                    s_next.st = BUS_ACTIVE;
                end
            end
            BUS_RESUMING: begin
                s_next.cnt = s_reg.cnt + 32'h1;
                if (s_reg.cnt == RESUME_LEN - 1) begin
                    s_next.st = BUS_ACTIVE;
                    s_next.ev_resumed = 1'b1;
                end
            end
            BUS_RESETTING: begin
                s_next.cnt = s_reg.cnt + 32'h1;
                if (s_reg.cnt == RESET_LEN - 1) begin
                    s_next.st = BUS_ACTIVE;
                    s_next.ev_reset_end = 1'b1;
                end
            end
            default: s_next.st = BUS_ACTIVE;
        endcase
        // peripheral: long se0 is a bus reset, also straight out of suspend
        if (!host_role && se0 && s_reg.se0_cnt == SE0_LAST - 12'h001) begin
            s_next.st = BUS_ACTIVE;
            s_next.ev_bus_reset = 1'b1;
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '{st: BUS_ACTIVE, cnt: 32'h0, se0_cnt: 12'h000, default: 1'b0};
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign state        = s_reg.st;
    assign ev_bus_reset = s_reg.ev_bus_reset;
    assign ev_resumed   = s_reg.ev_resumed;
    assign ev_reset_end = s_reg.ev_reset_end;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_host_suspend;
        ce && host_role && !reset_cmd && !s_reg.ev_bus_reset && s_reg.st == BUS_ACTIVE && suspend_req
            |=> s_reg.st == BUS_SUSPENDED;
    endproperty
    a_host_suspend: assert property (p_host_suspend) else $error("suspend request not honoured");

    property p_reset_from_suspend;
        ce && host_role && reset_cmd && s_reg.st == BUS_SUSPENDED |=> s_reg.st == BUS_RESETTING && s_reg.cnt == 32'h0;
    endproperty
    a_reset_from_suspend: assert property (p_reset_from_suspend) else $error("reset ignored in suspend");

    property p_periph_reset;
        ce && !host_role && se0 && s_reg.st == BUS_SUSPENDED && s_reg.se0_cnt == SE0_LAST - 12'h001
            |=> s_reg.ev_bus_reset && s_reg.st == BUS_ACTIVE;
    endproperty
    a_periph_reset: assert property (p_periph_reset) else $error("bus reset in suspend missed");

    c_host_reset_in_suspend: cover property (s_reg.st == BUS_SUSPENDED ##1 s_reg.st == BUS_RESETTING);
    c_periph_reset: cover property (!host_role && s_reg.ev_bus_reset);
endmodule

/* design/usb_rx_dma_susp_ctrl.sv */
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module usb_rx_dma_susp_ctrl
    import usb_rx_susp_pkg::*;
#(
    parameter int unsigned RESUME_LEN = RESUME_CYC,
    parameter int unsigned RESET_LEN  = RESET_CYC
) (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic             IRQ,
    input  wire logic        RX_PKT_DONE,
    input  wire logic        RX_PKT_SHORT,
    output logic             DMA_REQ,
    input  wire logic        DMA_ACK,
    input  wire logic        LINE_SE0,
    output logic             BUS_SUSPEND,
    output logic             BUS_RESUME,
    output logic             BUS_RESET
);
    typedef struct packed {
        logic             ack;
        logic [31:0]      rdata;
        logic             host;
        logic             suspend;
        logic             req_en;
        logic             req_mode;
        logic             rx_ready;
        logic             rx_short;
        logic             ch_en;
        logic             mode1;
        logic [15:0]      count;
        logic [IRQ_N-1:0] irq_st;
        logic [IRQ_N-1:0] irq_en;
        logic             se0_s1;
        logic             se0_s2;
    } ctl_t;

    ctl_t r_reg, r_next;
    bus_state_t bus_state;
    logic ev_bus_reset;
    logic ev_resumed;
    logic ev_reset_end;
    logic wr_go;
    logic resume_cmd;
    logic reset_cmd;
    logic auto_unload;
    logic dma_beat;
    logic [IRQ_N-1:0] irq_set;

    // true when the request targets the given register
    function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
        return addr == ofs;
    endfunction

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // one wait state per access; a frozen clock enable keeps the master waiting
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~(r_reg.ack & CE);
    assign wr_go = AVS_WRITE & r_reg.ack;
    assign AVS_READDATA = r_reg.rdata;

    // command pulses for the bus sequencer
    assign resume_cmd = wr_go && hit(AVS_ADDRESS, OFS_POWER) && AVS_BYTEENABLE[0] && AVS_WRITEDATA[PWR_RESUME];
    assign reset_cmd  = wr_go && hit(AVS_ADDRESS, OFS_POWER) && AVS_BYTEENABLE[0] && AVS_WRITEDATA[PWR_RESET];

    // full packet in dma mode 1 is unloaded without software; short one is not
    assign auto_unload = r_reg.mode1 & r_reg.ch_en & r_reg.req_en & r_reg.req_mode;
    assign DMA_REQ = r_reg.ch_en & r_reg.req_en & r_reg.rx_ready & (r_reg.count != 16'h0000)
                     & (~r_reg.mode1 | ~r_reg.rx_short);
    assign dma_beat = DMA_REQ & DMA_ACK;

    // interrupt events, one per cause
    always_comb begin
        irq_set = '0;
        // at most one rx event per packet, none for a full auto-unloaded one, never from a mode write
        irq_set[IRQ_RX] = RX_PKT_DONE & (RX_PKT_SHORT | ~auto_unload);
        irq_set[IRQ_DMA] = dma_beat & (r_reg.count == 16'h0001);
        irq_set[IRQ_BUS_RST] = ev_bus_reset;
        irq_set[IRQ_RESUMED] = ev_resumed;
        irq_set[IRQ_RST_END] = ev_reset_end;
    end

    // register file and receive bookkeeping
    always_comb begin
        logic [31:0] pw;
        logic [31:0] rx;
        logic [31:0] dc;
        pw = '0;
        rx = '0;
        dc = '0;
        r_next = r_reg;
        r_next.ack = (AVS_READ | AVS_WRITE) & ~r_reg.ack;
        r_next.se0_s1 = LINE_SE0;
        r_next.se0_s2 = r_reg.se0_s1;
        // read data captured in the wait cycle, stands at the answer edge
        if (AVS_READ && !r_reg.ack) begin
            r_next.rdata = 32'h0;
            if (hit(AVS_ADDRESS, OFS_POWER)) begin
                r_next.rdata[PWR_HOST] = r_reg.host;
                r_next.rdata[PWR_SUSPEND] = r_reg.suspend;
                r_next.rdata[PWR_STATE +: 2] = bus_state;
            end
            if (hit(AVS_ADDRESS, OFS_RX_CSR)) begin
                r_next.rdata[RX_READY] = r_reg.rx_ready;
                r_next.rdata[RX_SHORT] = r_reg.rx_short;
                r_next.rdata[RX_REQ_MODE] = r_reg.req_mode;
                r_next.rdata[RX_REQ_EN] = r_reg.req_en;
            end
            if (hit(AVS_ADDRESS, OFS_DMA_CTL)) begin
                r_next.rdata[DMA_EN] = r_reg.ch_en;
                r_next.rdata[DMA_MODE] = r_reg.mode1;
            end
            if (hit(AVS_ADDRESS, OFS_DMA_CNT)) begin
                r_next.rdata[15:0] = r_reg.count;
            end
            if (hit(AVS_ADDRESS, OFS_IRQ_ST)) begin
                r_next.rdata[IRQ_N-1:0] = r_reg.irq_st;
            end
            if (hit(AVS_ADDRESS, OFS_IRQ_EN)) begin
                r_next.rdata[IRQ_N-1:0] = r_reg.irq_en;
            end
        end
        // software writes, byte lanes honoured except for the irq enable and clear registers
        if (wr_go) begin
            pw = merge({28'h0, 1'b0, 1'b0, r_reg.suspend, r_reg.host}, AVS_WRITEDATA, AVS_BYTEENABLE);
            rx = merge({26'h0, r_reg.req_en, 1'b0, r_reg.req_mode, 2'b00, r_reg.rx_ready},
                       AVS_WRITEDATA, AVS_BYTEENABLE);
            dc = merge({29'h0, r_reg.mode1, 1'b0, r_reg.ch_en}, AVS_WRITEDATA, AVS_BYTEENABLE);
            if (hit(AVS_ADDRESS, OFS_POWER)) begin
                r_next.host = pw[PWR_HOST];
                r_next.suspend = pw[PWR_SUSPEND];
            end
            if (hit(AVS_ADDRESS, OFS_RX_CSR)) begin
                // software can only clear ready, never set it; request bits kept by the driver
                r_next.rx_ready = r_reg.rx_ready & rx[RX_READY];
                r_next.req_mode = rx[RX_REQ_MODE];
                r_next.req_en = rx[RX_REQ_EN];
            end
            if (hit(AVS_ADDRESS, OFS_DMA_CTL)) begin
                r_next.ch_en = dc[DMA_EN];
                r_next.mode1 = dc[DMA_MODE];
            end
            if (hit(AVS_ADDRESS, OFS_DMA_CNT)) begin
                r_next.count = 16'(merge({16'h0, r_reg.count}, AVS_WRITEDATA, AVS_BYTEENABLE));
            end
            if (hit(AVS_ADDRESS, OFS_IRQ_EN)) begin
                r_next.irq_en = AVS_WRITEDATA[IRQ_N-1:0];
            end
            if (hit(AVS_ADDRESS, OFS_IRQ_CLR)) begin
                r_next.irq_st = r_reg.irq_st & ~AVS_WRITEDATA[IRQ_N-1:0];
            end
        end
        // a resume or reset command, or a bus reset seen, ends the suspend request
        if (resume_cmd || reset_cmd || ev_bus_reset) begin
            r_next.suspend = 1'b0;
        end
        // dma beats count down; full mode-1 packet frees the fifo itself
        if (dma_beat) begin
            r_next.count = r_reg.count - 16'h0001;
            if (r_reg.count == 16'h0001 && r_reg.mode1 && !r_reg.rx_short) begin
                r_next.rx_ready = 1'b0;
            end
        end
        // packet arrival wins over a clear in the same cycle
        if (RX_PKT_DONE) begin
            r_next.rx_ready = 1'b1;
            r_next.rx_short = RX_PKT_SHORT;
        end
        r_next.irq_st = r_next.irq_st | irq_set;
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            r_reg <= '{count: DMA_CNT_RST, irq_st: IRQ_RST, irq_en: IRQ_RST, rdata: 32'h0, default: 1'b0};
        end else if (CE) begin
            r_reg <= r_next;
        end
    end

    // suspend, resume and reset sequencing of the bus
    usb_bus_power_seq #(
        .RESUME_LEN (RESUME_LEN),
        .RESET_LEN  (RESET_LEN)
    ) u_seq (
        .clk          (MCLK),
        .rst_n        (RST_N),
        .ce           (CE),
        .host_role    (r_reg.host),
        .suspend_req  (r_reg.suspend),
        .resume_cmd   (resume_cmd & CE),
        .reset_cmd    (reset_cmd & CE),
        .se0          (r_reg.se0_s2),
        .state        (bus_state),
        .ev_bus_reset (ev_bus_reset),
        .ev_resumed   (ev_resumed),
        .ev_reset_end (ev_reset_end)
    );

    // resume and reset drive only in host role, suspend in both roles; state decode comes straight from flops
    assign BUS_SUSPEND = bus_state == BUS_SUSPENDED;
    assign BUS_RESUME  = r_reg.host && bus_state == BUS_RESUMING;
    assign BUS_RESET   = r_reg.host && bus_state == BUS_RESETTING;
    assign IRQ = |(r_reg.irq_st & r_reg.irq_en);

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    property p_short_irq;
        CE && RX_PKT_DONE && RX_PKT_SHORT |=> r_reg.irq_st[IRQ_RX] && r_reg.rx_ready && r_reg.rx_short;
    endproperty
    a_short_irq: assert property (p_short_irq) else $error("short packet gave no rx interrupt");

    property p_single_irq;
        $rose(r_reg.irq_st[IRQ_RX]) |-> $past(RX_PKT_DONE) && $past(CE);
    endproperty
    a_single_irq: assert property (p_single_irq) else $error("rx interrupt without packet");

    property p_mode_write_quiet;
        CE && wr_go && hit(AVS_ADDRESS, OFS_DMA_CTL) && !RX_PKT_DONE && !r_reg.irq_st[IRQ_RX]
            |=> !r_reg.irq_st[IRQ_RX];
    endproperty
    a_mode_write_quiet: assert property (p_mode_write_quiet) else $error("mode switch raised rx irq");

    property p_full_auto_quiet;
        CE && RX_PKT_DONE && !RX_PKT_SHORT && auto_unload && !r_reg.irq_st[IRQ_RX] |=> !r_reg.irq_st[IRQ_RX];
    endproperty
    a_full_auto_quiet: assert property (p_full_auto_quiet) else $error("full mode-1 packet raised irq");

    property p_suspend_line;
        CE && r_reg.host && r_reg.suspend && bus_state == BUS_ACTIVE && !reset_cmd |=> BUS_SUSPEND;
    endproperty
    a_suspend_line: assert property (p_suspend_line) else $error("bus not suspended");

    property p_reset_line;
        CE && r_reg.host && bus_state == BUS_SUSPENDED && reset_cmd |=> BUS_RESET && !BUS_SUSPEND;
    endproperty
    a_reset_line: assert property (p_reset_line) else $error("reset not driven from suspend");

    property p_periph_irq;
        ev_bus_reset && CE |=> r_reg.irq_st[IRQ_BUS_RST];
    endproperty
    a_periph_irq: assert property (p_periph_irq) else $error("bus reset not flagged");

    property p_reset_wakes;
        CE && ev_bus_reset |=> !r_reg.suspend && !BUS_SUSPEND ##1 !BUS_SUSPEND;
    endproperty
    a_reset_wakes: assert property (p_reset_wakes) else $error("suspend kept after bus reset");

    // bus, clock-enable and dma guards
    property p_ce_freeze;
        !CE |=> $stable(r_reg);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while frozen");

    property p_wait_state;
        CE && (AVS_READ || AVS_WRITE) && !r_reg.ack |-> AVS_WAITREQUEST ##1 r_reg.ack;
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("wait state missing");

    property p_dma_done;
        CE && dma_beat && r_reg.count == 16'h0001 |=> r_reg.irq_st[IRQ_DMA] && r_reg.count == 16'h0000;
    endproperty
    a_dma_done: assert property (p_dma_done) else $error("dma done not flagged");

    property p_auto_free;
        CE && dma_beat && r_reg.count == 16'h0001 && r_reg.mode1 && !r_reg.rx_short && !RX_PKT_DONE
            |=> !r_reg.rx_ready;
    endproperty
    a_auto_free: assert property (p_auto_free) else $error("full mode-1 packet not freed");

    c_short_irq: cover property (RX_PKT_DONE && RX_PKT_SHORT && auto_unload);
    c_dma_done: cover property (irq_set[IRQ_DMA]);
    c_wait_answer: cover property (AVS_READ && AVS_WAITREQUEST ##1 AVS_READ && !AVS_WAITREQUEST);
endmodule

/* bench/usb_far_end.sv */
`timescale 1ns/1ns
// far side of the link: packet arrivals and line state seen through the phy
module usb_far_end (
    input  wire logic clk,
    output logic      pkt_done,
    output logic      pkt_short,
    output logic      line_se0
);
    initial begin
        pkt_done  = 1'b0;
        pkt_short = 1'b0;
        line_se0  = 1'b0;
    end

    // one packet lands in the fifo; short flag only valid with the pulse
    task automatic send_pkt(input logic s);
        @(posedge clk);
        pkt_done  <= 1'b1;
        pkt_short <= s;
        @(posedge clk);
        pkt_done  <= 1'b0;
        pkt_short <= ~s; // stale flag inverted so nothing relies on it
    endtask

    // bus reset from the far host: se0 held for n cycles, then released
    task automatic drive_se0(input int n);
        @(posedge clk);
        line_se0 <= 1'b1;
        repeat (n) @(posedge clk);
        line_se0 <= 1'b0;
    endtask
endmodule

/* bench/usb_rx_dma_susp_ctrl_tb.sv */
`timescale 1ns/1ns
module usb_rx_dma_susp_ctrl_tb import usb_rx_susp_pkg::*;;
    logic        MCLK = 1'b0;
    logic        RST_N = 1'b0;
    logic [4:0]  AVS_ADDRESS = 5'h00;
    logic        AVS_READ = 1'b0;
    logic        AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [31:0] AVS_READDATA;
    logic        AVS_WAITREQUEST, IRQ, DMA_REQ, BUS_SUSPEND, BUS_RESUME, BUS_RESET;
    logic        RX_PKT_DONE, RX_PKT_SHORT, LINE_SE0;
    logic        DMA_ACK = 1'b0;
    logic        CE = 1'b1;
    logic [3:0]  AVS_BYTEENABLE = 4'hf;
    logic [31:0] rd;
    int          fail_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          ack_count = 0;
    int          ack_base;
    int          exp_waits = 2;

    always #5 MCLK = ~MCLK;

    // short lengths keep resume and reset runs brief
    usb_rx_dma_susp_ctrl #(.RESUME_LEN(20), .RESET_LEN(30)) u_dut (
        .MCLK(MCLK), .RST_N(RST_N), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ),
        .RX_PKT_DONE(RX_PKT_DONE), .RX_PKT_SHORT(RX_PKT_SHORT), .DMA_REQ(DMA_REQ), .DMA_ACK(DMA_ACK),
        .LINE_SE0(LINE_SE0), .BUS_SUSPEND(BUS_SUSPEND), .BUS_RESUME(BUS_RESUME), .BUS_RESET(BUS_RESET)
    );

    usb_far_end u_far (.clk(MCLK), .pkt_done(RX_PKT_DONE), .pkt_short(RX_PKT_SHORT), .line_se0(LINE_SE0));

    // slow dma mover: one word every other cycle, so the count is seen stalling
    always @(posedge MCLK) begin
        DMA_ACK <= DMA_REQ & ~DMA_ACK;
        if (DMA_REQ & DMA_ACK) begin
            ack_count <= ack_count + 1;
        end
    end

    // hang guard, well above the several hundred cycles the run needs
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            final_report;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bit_chk(input string what, input logic seen, input logic exp);
        check(what, {31'h0, seen}, {31'h0, exp});
    endtask

    // one avalon access; request held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge MCLK);
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE     <= wr;
        AVS_READ      <= ~wr;
        do begin
            @(posedge MCLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0);
        check("wait cycles", n, exp_waits);
        rd = AVS_READDATA;
        AVS_READ  <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdchk(input string what, input logic [4:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    // settle point: outputs read one step after the edge
    task automatic step(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask

    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (IRQ !== 1'b1 && n < lim) begin
            @(posedge MCLK);
            n++;
        end
        bit_chk("irq raised", IRQ, 1'b1);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge MCLK);
        RST_N <= 1'b1;
        rdchk("status reset", OFS_IRQ_ST, {27'h0, IRQ_RST});
        rdchk("count reset", OFS_DMA_CNT, {16'h0, DMA_CNT_RST});
        wr(5'h1c, 32'hffff_ffff);
        rdchk("unmapped", 5'h1c, 32'h0);
        bit_chk("irq idle", IRQ, 1'b0);
        // one byte lane written, then a read stretched by a frozen clock enable
        AVS_BYTEENABLE <= 4'h1;
        wr(OFS_DMA_CNT, 32'h1234_5678);
        AVS_BYTEENABLE <= 4'hf;
        exp_waits = 5;
        fork
            rdchk("lane and freeze", OFS_DMA_CNT, 32'h78);
            begin
                @(posedge MCLK);
                CE <= 1'b0;
                repeat (3) @(posedge MCLK);
                CE <= 1'b1;
            end
        join
        exp_waits = 2;
        $display("test reset done");

        // short last packet in mode 1, then takeover by the cpu
        wr(OFS_IRQ_EN, 32'h1 << IRQ_RX);
        wr(OFS_DMA_CTL, 32'h5);
        wr(OFS_DMA_CNT, 32'h8);
        wr(OFS_RX_CSR, 32'h28);
        u_far.send_pkt(1'b1);
        step(2);
        bit_chk("irq short", IRQ, 1'b1);
        bit_chk("no mode1 dma on short", DMA_REQ, 1'b0);
        rdchk("rx csr", OFS_RX_CSR, 32'h2b);
        wr(OFS_IRQ_CLR, 32'h1);
        wr(OFS_RX_CSR, 32'h28);
        wr(OFS_RX_CSR, 32'h00);
        step(4);
        rdchk("no second rx irq", OFS_IRQ_ST, 32'h0);
        bit_chk("irq quiet", IRQ, 1'b0);
        // masked arrival stays pending and shows once enabled
        wr(OFS_IRQ_EN, 32'h0);
        u_far.send_pkt(1'b1);
        step(2);
        bit_chk("irq masked", IRQ, 1'b0);
        rdchk("status masked", OFS_IRQ_ST, 32'h1);
        wr(OFS_IRQ_EN, 32'h1);
        step(1);
        bit_chk("irq unmasked", IRQ, 1'b1);
        wr(OFS_IRQ_CLR, 32'h1);
        step(1);
        bit_chk("irq cleared", IRQ, 1'b0);
        $display("test cpu takeover done");

        // short last packet in mode 1, then switch to dma mode 0
        wr(OFS_DMA_CNT, 32'h0);
        wr(OFS_RX_CSR, 32'h28);
        wr(OFS_DMA_CTL, 32'h5);
        u_far.send_pkt(1'b1);
        step(2);
        rdchk("status arrival", OFS_IRQ_ST, 32'h1);
        wr(OFS_IRQ_CLR, 32'h1);
        wr(OFS_IRQ_EN, 32'h3);
        ack_base = ack_count;
        wr(OFS_DMA_CTL, 32'h1);
        wr(OFS_DMA_CNT, 32'h3);
        wait_irq(100);
        rdchk("dma done only", OFS_IRQ_ST, 32'h2);
        check("words moved", ack_count - ack_base, 32'h3);
        bit_chk("dma req ends", DMA_REQ, 1'b0);
        wr(OFS_RX_CSR, 32'h28);
        wr(OFS_IRQ_CLR, 32'h3);
        step(3);
        rdchk("no spurious rx", OFS_IRQ_ST, 32'h0);
        $display("test dma mode0 done");

        // full packet in mode 1 is unloaded by dma alone, no rx interrupt
        wr(OFS_DMA_CTL, 32'h5);
        wr(OFS_DMA_CNT, 32'h4);
        ack_base = ack_count;
        u_far.send_pkt(1'b0);
        wait_irq(100);
        rdchk("full pkt no rx irq", OFS_IRQ_ST, 32'h2);
        check("full words", ack_count - ack_base, 32'h4);
        rdchk("ready freed", OFS_RX_CSR, 32'h28);
        wr(OFS_IRQ_CLR, 32'h3);
        $display("test full mode1 done");

        // host: suspend, then reset straight from suspend
        wr(OFS_IRQ_EN, 32'h18);
        wr(OFS_POWER, 32'h3);
        step(3);
        bit_chk("host suspended", BUS_SUSPEND, 1'b1);
        rdchk("power suspended", OFS_POWER, 32'h13);
        wr(OFS_POWER, 32'h9);
        step(3);
        bit_chk("reset driven", BUS_RESET, 1'b1);
        bit_chk("suspend left", BUS_SUSPEND, 1'b0);
        wait_irq(100);
        rdchk("reset end", OFS_IRQ_ST, 32'h10);
        bit_chk("reset released", BUS_RESET, 1'b0);
        wr(OFS_IRQ_CLR, 32'h1f);
        // resume first, then reset
        wr(OFS_POWER, 32'h3);
        step(3);
        wr(OFS_POWER, 32'h5);
        step(3);
        bit_chk("resume driven", BUS_RESUME, 1'b1);
        wait_irq(100);
        rdchk("resume end", OFS_IRQ_ST, 32'h08);
        wr(OFS_IRQ_CLR, 32'h1f);
        wr(OFS_POWER, 32'h9);
        wait_irq(100);
        rdchk("reset after resume", OFS_IRQ_ST, 32'h10);
        wr(OFS_IRQ_CLR, 32'h1f);
        $display("test host suspend done");

        // peripheral: far host resets the bus while suspended
        wr(OFS_IRQ_EN, 32'h4);
        wr(OFS_POWER, 32'h2);
        step(3);
        bit_chk("dev suspended", BUS_SUSPEND, 1'b1);
        u_far.drive_se0(300);
        wait_irq(50);
        rdchk("reset seen", OFS_IRQ_ST, 32'h04);
        bit_chk("dev active", BUS_SUSPEND, 1'b0);
        rdchk("dev power", OFS_POWER, 32'h0);
        bit_chk("dev drives no reset", BUS_RESET, 1'b0);
        $display("test device reset done");
        final_report;
    end
endmodule
